// ### design/pgb_defs.svh
// Functional notes
// - Flag register read-only, zero reset, bit7 zero
// - Bit6: linreg three regulating or switch
// - Bit5: linreg four regulating or switch
// - Bit4: buck one in regulation
// - Bit3: buck two in regulation
// - Bit2: buck three in regulation
// - Bits1,0: linreg one, two regulating
// - Control resets 0x0c, upper nibble reads zero
// - Protected registers written only when unlocked
// - Control bit3 masks linreg one flag
// - Control bit2 masks linreg two flag
// - Delay field selects 20/100/200/400 ms
// - Buck one bit7 external adjust, bit6 zero
// - Buck one six-bit code from 0.9 V
// - Buck one code reset per variant
// - Buck two layout and variant reset code
// - Key allows one next write, then clears
// - Buck two adjust select and code encoding
`ifndef PGB_DEFS_SVH
`define PGB_DEFS_SVH

// Register offsets
`define PGB_OFS_KEY        8'h0b
`define PGB_OFS_FLAGS      8'h0c
`define PGB_OFS_CTRL       8'h0d
`define PGB_OFS_BUCK_ONE   8'h0e
`define PGB_OFS_BUCK_TWO   8'h0f

// Reset values
`define PGB_RST_KEY        8'h00
`define PGB_RST_FLAGS      8'h00
`define PGB_RST_CTRL       8'h0c
`define PGB_UNLOCK_VALUE   8'h7d
`define PGB_B1_RST_V0      6'h1e
`define PGB_B1_RST_V1      6'h1e
`define PGB_B1_RST_V2      6'h18
`define PGB_B1_RST_V3      6'h12
`define PGB_B2_RST_V0      6'h38
`define PGB_B2_RST_V1      6'h08
`define PGB_B2_RST_V2      6'h08
`define PGB_B2_RST_V3      6'h08

// Field positions
`define PGB_FLG_LIN3       6
`define PGB_FLG_LIN4       5
`define PGB_FLG_BUCK1      4
`define PGB_FLG_BUCK2      3
`define PGB_FLG_BUCK3      2
`define PGB_FLG_LIN1       1
`define PGB_FLG_LIN2       0
`define PGB_CTL_MASK1      3
`define PGB_CTL_MASK2      2
`define PGB_CTL_DLY_HI     1
`define PGB_CTL_DLY_LO     0
`define PGB_BCK_XADJ       7
`define PGB_BCK_CODE_HI    5

// Timing
`define PGB_CLK_KHZ        100000
`define PGB_DLY0_MS        20
`define PGB_DLY1_MS        100
`define PGB_DLY2_MS        200
`define PGB_DLY3_MS        400

`endif

// ### design/pgb_pkg.sv
package pgb_pkg;
   typedef enum logic [2:0] {
      PGB_ST_LOW  = 3'b001,
      PGB_ST_WAIT = 3'b010,
      PGB_ST_HIGH = 3'b100
   } pgb_state_e;
   typedef logic [7:0] pgb_byte_t;
endpackage

// ### design/pgb_sync.sv
`timescale 1ns/100ps
module pgb_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] out_reg;
   logic [W-1:0] out_next;

   initial begin
      if (W < 1) $error("pgb_sync width must be at least one");
   end

   always_comb begin
      meta_next = din;
      out_next  = meta_reg;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         out_reg  <= '0;
      end else begin
         meta_reg <= meta_next;
         out_reg  <= out_next;
      end
   end

   assign dout = out_reg;
endmodule

// ### design/pgb_regs.sv
`timescale 1ns/100ps
`include "pgb_defs.svh"
module pgb_regs
   import pgb_pkg::*;
#(
   parameter int unsigned VARIANT  = 0,
   parameter int unsigned CNT_W    = 26,
   parameter int unsigned DLY0_CYC = `PGB_DLY0_MS * `PGB_CLK_KHZ,
   parameter int unsigned DLY1_CYC = `PGB_DLY1_MS * `PGB_CLK_KHZ,
   parameter int unsigned DLY2_CYC = `PGB_DLY2_MS * `PGB_CLK_KHZ,
   parameter int unsigned DLY3_CYC = `PGB_DLY3_MS * `PGB_CLK_KHZ
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   input  wire logic [7:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   output logic            bus_rvalid,
   input  wire logic       linreg_one_ok_raw,
   input  wire logic       linreg_two_ok_raw,
   input  wire logic       linreg_three_ok_raw,
   input  wire logic       linreg_four_ok_raw,
   input  wire logic       linreg_three_is_switch,
   input  wire logic       linreg_four_is_switch,
   input  wire logic       buck_one_ok_raw,
   input  wire logic       buck_two_ok_raw,
   input  wire logic       buck_three_ok_raw,
   output logic            power_good_out,
   output logic            power_good_oe_n,
   output logic            buck_one_external_adjust,
   output logic      [5:0] buck_one_code,
   output logic            buck_two_external_adjust,
   output logic      [5:0] buck_two_code
);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks and variant resets
   localparam logic [5:0] B1_RST = (VARIANT == 0) ? `PGB_B1_RST_V0 :
                                   (VARIANT == 1) ? `PGB_B1_RST_V1 :
                                   (VARIANT == 2) ? `PGB_B1_RST_V2 : `PGB_B1_RST_V3;
   localparam logic [5:0] B2_RST = (VARIANT == 0) ? `PGB_B2_RST_V0 :
                                   (VARIANT == 1) ? `PGB_B2_RST_V1 :
                                   (VARIANT == 2) ? `PGB_B2_RST_V2 : `PGB_B2_RST_V3;
   localparam logic [7:0] B1_RST_BYTE = {2'b00, B1_RST};
   localparam logic [7:0] B2_RST_BYTE = {2'b00, B2_RST};

   initial begin
      if (VARIANT > 3) $error("pgb_regs VARIANT must be 0 to 3");
      if (CNT_W < 2 || CNT_W > 31) $error("pgb_regs CNT_W out of range");
      if (DLY0_CYC < 1 || DLY1_CYC < 1 || DLY2_CYC < 1 || DLY3_CYC < 1)
         $error("pgb_regs delays must be at least one cycle");
      if (DLY0_CYC >= (1 << CNT_W) || DLY1_CYC >= (1 << CNT_W) ||
          DLY2_CYC >= (1 << CNT_W) || DLY3_CYC >= (1 << CNT_W))
         $error("pgb_regs delay does not fit the counter");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flag input synchronisers
   logic [8:0] raw_in;
   logic [8:0] syn;

   assign raw_in = {linreg_four_is_switch, linreg_three_is_switch, linreg_one_ok_raw,
                    linreg_two_ok_raw, linreg_three_ok_raw, linreg_four_ok_raw,
                    buck_one_ok_raw, buck_two_ok_raw, buck_three_ok_raw};

   pgb_sync #(
      .W (9)
   ) u_pgb_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .din     (raw_in),
      .dout    (syn)
   );

   logic s_buck3;
   logic s_buck2;
   logic s_buck1;
   logic s_lin4;
   logic s_lin3;
   logic s_lin2;
   logic s_lin1;
   logic s_sw3;
   logic s_sw4;

   assign s_buck3 = syn[0];
   assign s_buck2 = syn[1];
   assign s_buck1 = syn[2];
   assign s_lin4  = syn[3];
   assign s_lin3  = syn[4];
   assign s_lin2  = syn[5];
   assign s_lin1  = syn[6];
   assign s_sw3   = syn[7];
   assign s_sw4   = syn[8];

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   pgb_byte_t key_reg;
   pgb_byte_t key_next;
   pgb_byte_t flags_reg;
   pgb_byte_t flags_next;
   pgb_byte_t ctrl_reg;
   pgb_byte_t ctrl_next;
   pgb_byte_t buck1_reg;
   pgb_byte_t buck1_next;
   pgb_byte_t buck2_reg;
   pgb_byte_t buck2_next;
   pgb_byte_t rdata_reg;
   pgb_byte_t rdata_next;
   logic      rvalid_reg;
   logic      rvalid_next;
   logic      unlocked;

   assign unlocked = (key_reg == `PGB_UNLOCK_VALUE);

   always_comb begin
      flags_next = 8'h00;
      flags_next[`PGB_FLG_LIN3]  = s_lin3 | s_sw3;
      flags_next[`PGB_FLG_LIN4]  = s_lin4 | s_sw4;
      flags_next[`PGB_FLG_BUCK1] = s_buck1;
      flags_next[`PGB_FLG_BUCK2] = s_buck2;
      flags_next[`PGB_FLG_BUCK3] = s_buck3;
      flags_next[`PGB_FLG_LIN1]  = s_lin1;
      flags_next[`PGB_FLG_LIN2]  = s_lin2;
      key_next   = key_reg;
      ctrl_next  = ctrl_reg;
      buck1_next = buck1_reg;
      buck2_next = buck2_reg;
      if (bus_wr) begin
         if (bus_addr == `PGB_OFS_KEY) begin
            key_next = bus_wdata;
         end else begin
            key_next = `PGB_RST_KEY;
         end
         if (unlocked) begin
            case (bus_addr)
               `PGB_OFS_CTRL: begin
                  ctrl_next = {4'h0, bus_wdata[3:0]};
               end
               `PGB_OFS_BUCK_ONE: begin
                  buck1_next = {bus_wdata[7], 1'b0, bus_wdata[5:0]};
               end
               `PGB_OFS_BUCK_TWO: begin
                  buck2_next = {bus_wdata[7], 1'b0, bus_wdata[5:0]};
               end
               default: begin
               end
            endcase
         end
      end
      rvalid_next = bus_rd;
      rdata_next  = rdata_reg;
      if (bus_rd) begin
         case (bus_addr)
            `PGB_OFS_KEY:      rdata_next = key_reg;
            `PGB_OFS_FLAGS:    rdata_next = flags_reg;
            `PGB_OFS_CTRL:     rdata_next = ctrl_reg;
            `PGB_OFS_BUCK_ONE: rdata_next = buck1_reg;
            `PGB_OFS_BUCK_TWO: rdata_next = buck2_reg;
            default:           rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_reg    <= `PGB_RST_KEY;
         flags_reg  <= `PGB_RST_FLAGS;
         ctrl_reg   <= `PGB_RST_CTRL;
         buck1_reg  <= B1_RST_BYTE;
         buck2_reg  <= B2_RST_BYTE;
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         key_reg    <= key_next;
         flags_reg  <= flags_next;
         ctrl_reg   <= ctrl_next;
         buck1_reg  <= buck1_next;
         buck2_reg  <= buck2_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign bus_rdata                = rdata_reg;
   assign bus_rvalid               = rvalid_reg;
   assign buck_one_external_adjust = buck1_reg[`PGB_BCK_XADJ];
   assign buck_one_code            = buck1_reg[`PGB_BCK_CODE_HI:0];
   assign buck_two_external_adjust = buck2_reg[`PGB_BCK_XADJ];
   assign buck_two_code            = buck2_reg[`PGB_BCK_CODE_HI:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Power-good pin timer
   pgb_state_e       state_reg;
   pgb_state_e       state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] lim_m1;
   logic             oe_n_reg;
   logic             oe_n_next;
   logic             all_ok;

   assign all_ok = s_buck1 & s_buck2 & s_buck3 & (s_lin3 | s_sw3) & (s_lin4 | s_sw4) &
                   (s_lin1 | ctrl_reg[`PGB_CTL_MASK1]) &
                   (s_lin2 | ctrl_reg[`PGB_CTL_MASK2]);

   always_comb begin
      case (ctrl_reg[`PGB_CTL_DLY_HI:`PGB_CTL_DLY_LO])
         2'b00:   lim_m1 = CNT_W'(DLY0_CYC - 1);
         2'b01:   lim_m1 = CNT_W'(DLY1_CYC - 1);
         2'b10:   lim_m1 = CNT_W'(DLY2_CYC - 1);
         default: lim_m1 = CNT_W'(DLY3_CYC - 1);
      endcase
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         PGB_ST_LOW: begin
            cnt_next = '0;
            if (all_ok) state_next = PGB_ST_WAIT;
         end
         PGB_ST_WAIT: begin
            if (!all_ok) begin
               state_next = PGB_ST_LOW;
               cnt_next   = '0;
            end else if (cnt_reg >= lim_m1) begin
               state_next = PGB_ST_HIGH;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         PGB_ST_HIGH: begin
            if (!all_ok) state_next = PGB_ST_LOW;
         end
         default: begin
            state_next = PGB_ST_LOW;
            cnt_next   = '0;
         end
      endcase
      oe_n_next = (state_next == PGB_ST_HIGH);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PGB_ST_LOW;
         cnt_reg   <= '0;
         oe_n_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         oe_n_reg  <= oe_n_next;
      end
   end

   assign power_good_out  = 1'b0;
   assign power_good_oe_n = oe_n_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_flags_top_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      flags_reg[7] == 1'b0;
   endproperty
   a_flags_top_zero: assert property (p_flags_top_zero)
      else $error("flag register bit 7 not zero");

   property p_lin3_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      ##1 flags_reg[`PGB_FLG_LIN3] == $past(s_lin3 | s_sw3);
   endproperty
   a_lin3_flag: assert property (p_lin3_flag)
      else $error("linreg three flag mismatch");

   property p_buck1_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      ##1 flags_reg[`PGB_FLG_BUCK1] == $past(s_buck1);
   endproperty
   a_buck1_flag: assert property (p_buck1_flag)
      else $error("buck one flag mismatch");

   property p_ctrl_upper;
      @(posedge ref_clk) disable iff (!rst_n)
      ctrl_reg[7:4] == 4'h0;
   endproperty
   a_ctrl_upper: assert property (p_ctrl_upper)
      else $error("control upper nibble not zero");

   property p_locked;
      @(posedge ref_clk) disable iff (!rst_n)
      (bus_wr && !unlocked) |=> ($stable(ctrl_reg) && $stable(buck1_reg) && $stable(buck2_reg));
   endproperty
   a_locked: assert property (p_locked)
      else $error("protected register changed while locked");

   property p_key_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      (bus_wr && bus_addr != `PGB_OFS_KEY) |=> key_reg == 8'h00;
   endproperty
   a_key_clear: assert property (p_key_clear)
      else $error("key not cleared after write");

   property p_mask1;
      @(posedge ref_clk) disable iff (!rst_n)
      (!ctrl_reg[`PGB_CTL_MASK1] && !s_lin1) |=> !power_good_oe_n;
   endproperty
   a_mask1: assert property (p_mask1)
      else $error("unmasked linreg one low did not pull pin");

   property p_mask2;
      @(posedge ref_clk) disable iff (!rst_n)
      (!ctrl_reg[`PGB_CTL_MASK2] && !s_lin2) |=> !power_good_oe_n;
   endproperty
   a_mask2: assert property (p_mask2)
      else $error("unmasked linreg two low did not pull pin");

   property p_release;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(power_good_oe_n) |-> $past(cnt_reg) == $past(lim_m1);
   endproperty
   a_release: assert property (p_release)
      else $error("pin released before selected delay");

   property p_drop;
      @(posedge ref_clk) disable iff (!rst_n)
      !all_ok |=> !power_good_oe_n;
   endproperty
   a_drop: assert property (p_drop)
      else $error("pin not pulled low after flag drop");

   property p_buck_res;
      @(posedge ref_clk) disable iff (!rst_n)
      buck1_reg[6] == 1'b0 && buck2_reg[6] == 1'b0;
   endproperty
   a_buck_res: assert property (p_buck_res)
      else $error("buck reserved bit set");

endmodule

// ### bench/pgb_host_model.sv
`timescale 1ns/100ps
`include "pgb_defs.svh"
module pgb_host_model (
   input  wire logic       ref_clk,
   output logic            bus_wr,
   output logic            bus_rd,
   output logic      [7:0] bus_addr,
   output logic      [7:0] bus_wdata
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_addr  = 8'h00;
      bus_wdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Single byte write, bus scrambled after release
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      #1;
      bus_wr    = 1'b1;
      bus_addr  = addr;
      bus_wdata = data;
      @(posedge ref_clk);
      #1;
      bus_wr    = 1'b0;
      bus_addr  = ~addr;
      bus_wdata = ~data;
   endtask

   // Single byte read strobe
   task automatic rd(input logic [7:0] addr);
      @(posedge ref_clk);
      #1;
      bus_rd   = 1'b1;
      bus_addr = addr;
      @(posedge ref_clk);
      #1;
      bus_rd   = 1'b0;
      bus_addr = ~addr;
   endtask

   // Key immediately before the protected write
   task automatic prot_wr(input logic [7:0] addr, input logic [7:0] data);
      wr(`PGB_OFS_KEY, `PGB_UNLOCK_VALUE);
      wr(addr, data);
   endtask
endmodule

// ### bench/test_power_good_and_buck_config_regs.sv
`timescale 1ns/100ps
module test_power_good_and_buck_config_regs;
   localparam int unsigned DLY_CYC [4] = '{5, 10, 20, 40};
   logic       ref_clk = 1'b0;
   logic       nrst    = 1'b0;
   logic       bus_wr;
   logic       bus_rd;
   logic [7:0] bus_addr;
   logic [7:0] bus_wdata;
   logic [7:0] bus_rdata;
   logic       bus_rvalid;
   logic [8:0] ok_vec  = 9'h000;
   logic       power_good_out;
   logic       power_good_oe_n;
   logic       pin_level;
   logic       b1_adj;
   logic [5:0] b1_code;
   logic       b2_adj;
   logic [5:0] b2_code;
   logic [15:0] lfsr = 16'h002d;
   logic [7:0] exp_q [$];
   int         bad_count = 0;
   int         n_checks  = 0;

   always #5 ref_clk = ~ref_clk;
   // Open-drain pin with pull-up
   assign pin_level = power_good_oe_n ? 1'b1 : power_good_out;

   ////////////////////////////////////////////////////////////////////////////
   pgb_host_model u_pgb_host_model (
      .ref_clk   (ref_clk),
      .bus_wr    (bus_wr),
      .bus_rd    (bus_rd),
      .bus_addr  (bus_addr),
      .bus_wdata (bus_wdata)
   );

   pgb_regs #(.VARIANT(0), .CNT_W(26), .DLY0_CYC(DLY_CYC[0]), .DLY1_CYC(DLY_CYC[1]),
      .DLY2_CYC(DLY_CYC[2]), .DLY3_CYC(DLY_CYC[3])) u_pgb_regs (
      .ref_clk                  (ref_clk),
      .nrst                     (nrst),
      .bus_wr                   (bus_wr),
      .bus_rd                   (bus_rd),
      .bus_addr                 (bus_addr),
      .bus_wdata                (bus_wdata),
      .bus_rdata                (bus_rdata),
      .bus_rvalid               (bus_rvalid),
      .linreg_one_ok_raw        (ok_vec[1]),
      .linreg_two_ok_raw        (ok_vec[0]),
      .linreg_three_ok_raw      (ok_vec[6]),
      .linreg_four_ok_raw       (ok_vec[5]),
      .linreg_three_is_switch   (ok_vec[8]),
      .linreg_four_is_switch    (ok_vec[7]),
      .buck_one_ok_raw          (ok_vec[4]),
      .buck_two_ok_raw          (ok_vec[3]),
      .buck_three_ok_raw        (ok_vec[2]),
      .power_good_out           (power_good_out),
      .power_good_oe_n          (power_good_oe_n),
      .buck_one_external_adjust (b1_adj),
      .buck_one_code            (b1_code),
      .buck_two_external_adjust (b2_adj),
      .buck_two_code            (b2_code)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic test_done();
      if (bad_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rd_exp(input logic [7:0] addr, input logic [7:0] exp);
      exp_q.push_back(exp);
      u_pgb_host_model.rd(addr);
   endtask

   task automatic set_ok(input logic [8:0] v);
      @(posedge ref_clk);
      #1;
      ok_vec = v;
   endtask

   // Cycles until pin reaches level, bounded
   task automatic wait_pin(input logic lvl, input int lo, input int hi);
      int n;
      n = 0;
      while (pin_level !== lvl && n <= hi) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      n_checks++;
      if (n < lo || n > hi) begin
         bad_count++;
         $display("Error at %0t: pin level %b after %0d cycles", $time, lvl, n);
      end
   endtask

   task automatic check_buck(input logic [7:0] b1, input logic [7:0] b2);
      check8({b1_adj, 1'b0, b1_code}, b1, "buck one outputs");
      check8({b2_adj, 1'b0, b2_code}, b2, "buck two outputs");
   endtask

   function automatic logic [7:0] flag_exp(input logic [8:0] v);
      return {1'b0, v[6] | v[8], v[5] | v[7], v[4:0]};
   endfunction

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Read result monitor, mid-cycle sample
   always @(negedge ref_clk) begin
      if (bus_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("Error at %0t: unexpected read data", $time);
         end else begin
            check8(bus_rdata, exp_q.pop_front(), "read data");
         end
      end
   end

   initial begin
      #400000;
      bad_count++;
      $display("Error at %0t: timeout", $time);
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0] ctl;
      repeat (5) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
      check_buck(8'h1e, 8'h38);
      rd_exp(8'h0b, 8'h00);
      rd_exp(8'h0c, 8'h00);
      rd_exp(8'h0d, 8'h0c);
      rd_exp(8'h0e, 8'h1e);
      rd_exp(8'h0f, 8'h38);
      rd_exp(8'h20, 8'h00);
      // Locked and wrong-key writes ignored
      u_pgb_host_model.wr(8'h0d, 8'h01);
      u_pgb_host_model.wr(8'h0e, 8'h3f);
      u_pgb_host_model.wr(8'h0f, 8'h80);
      u_pgb_host_model.wr(8'h0c, 8'hff);
      u_pgb_host_model.wr(8'h0b, 8'h7c);
      u_pgb_host_model.wr(8'h0d, 8'h01);
      rd_exp(8'h0c, 8'h00);
      rd_exp(8'h0d, 8'h0c);
      rd_exp(8'h0e, 8'h1e);
      rd_exp(8'h0f, 8'h38);
      check_buck(8'h1e, 8'h38);
      // Unlock admits one write only
      u_pgb_host_model.prot_wr(8'h0d, 8'hf3);
      rd_exp(8'h0b, 8'h00);
      rd_exp(8'h0d, 8'h03);
      u_pgb_host_model.wr(8'h0d, 8'h00);
      rd_exp(8'h0d, 8'h03);
      u_pgb_host_model.wr(8'h0b, 8'h7d);
      rd_exp(8'h0b, 8'h7d);
      u_pgb_host_model.wr(8'h0d, 8'h0c);
      rd_exp(8'h0d, 8'h0c);
      // Buck fields and boundaries
      u_pgb_host_model.prot_wr(8'h0e, 8'hff);
      rd_exp(8'h0e, 8'hbf);
      u_pgb_host_model.prot_wr(8'h0f, 8'h45);
      rd_exp(8'h0f, 8'h05);
      check_buck(8'hbf, 8'h05);
      u_pgb_host_model.prot_wr(8'h0e, 8'h00);
      u_pgb_host_model.prot_wr(8'h0f, 8'hc0);
      rd_exp(8'h0f, 8'h80);
      check_buck(8'h00, 8'h80);
      // Random regulator states into flag register
      for (int i = 0; i < 12; i++) begin
         lfsr = lfsr_next(lfsr);
         set_ok(lfsr[8:0]);
         repeat (4) @(posedge ref_clk);
         rd_exp(8'h0c, flag_exp(lfsr[8:0]));
      end
      // Every delay code, switch path on odd codes
      for (int d = 0; d < 4; d++) begin
         set_ok(9'h000);
         ctl = 8'h0c | 8'(d);
         u_pgb_host_model.prot_wr(8'h0d, ctl);
         wait_pin(1'b0, 0, 6);
         set_ok(d[0] ? 9'h19f : 9'h07f);
         wait_pin(1'b1, DLY_CYC[d] + 2, DLY_CYC[d] + 6);
         rd_exp(8'h0c, flag_exp(d[0] ? 9'h19f : 9'h07f));
      end
      // Masks for linreg one and two
      for (int m = 0; m < 2; m++) begin
         set_ok(9'h000);
         u_pgb_host_model.prot_wr(8'h0d, 8'h0c);
         set_ok(9'h07f);
         wait_pin(1'b1, 7, 11);
         set_ok(9'h07f & ~(9'h002 >> m));
         repeat (6) @(posedge ref_clk);
         check8({7'h00, pin_level}, 8'h01, "masked flag");
         u_pgb_host_model.prot_wr(8'h0d, 8'h0c & ~(8'h08 >> m));
         wait_pin(1'b0, 0, 3);
         set_ok(9'h07f);
         wait_pin(1'b1, 7, 11);
         set_ok(9'h07b);
         wait_pin(1'b0, 2, 4);
      end
      repeat (4) @(posedge ref_clk);
      check8(8'(exp_q.size()), 8'h00, "reads outstanding");
      test_done();
   end
endmodule
